// ===== core/aocal_pkg.sv
package aocal_pkg;

	// ****************************************************************
	// register map (holding-register addresses, zero based)
	// ****************************************************************
	localparam logic [15:0] ADDR_ACCESS = 16'h001E;
	localparam logic [15:0] ADDR_CH4_UPPER = 16'h0027;
	localparam logic [15:0] ADDR_CH4_LOWER = 16'h0028;
	localparam logic [15:0] ADDR_CH5_UPPER = 16'h0029;
	localparam logic [15:0] ADDR_CH5_LOWER = 16'h002A;
	localparam logic [15:0] ADDR_RSVD_FIRST = 16'h002B;
	localparam logic [15:0] ADDR_SPAN_SEL = 16'h0031;
	localparam logic [15:0] ADDR_ZERO_SEL = 16'h0032;
	// mirror window: reference 43001 is input address 0
	localparam logic [15:0] MIRROR_BASE = 16'h0BB8;
	localparam logic [15:0] MIRROR_SIZE = 16'h0400;

	// ****************************************************************
	// codes and reset values
	// ****************************************************************
	localparam logic [15:0] UNLOCK_CODE = 16'h5E2A;
	localparam logic [15:0] LOCK_CODE = 16'h0000;
	localparam logic [15:0] ACCESS_READ = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] SELECT_RESET = 16'h0000;
	localparam logic [15:0] RSVD_READ = 16'h0000;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} aocal_req_s;

	typedef struct packed {
		logic [15:0] ch4Upper;
		logic [15:0] ch4Lower;
		logic [15:0] ch5Upper;
		logic [15:0] ch5Lower;
	} aocal_ends_s;

endpackage

// ===== core/aocal_regs.sv
`timescale 1ns/1ps
// Function
// R1: span select: one-hot bit per channel
// R2: zero select: one-hot bit per channel
// R3: client unlocks with 5E2AH before selecting
// R4: input registers mirrored at reference plus 43000
// R5: hold channel four and five endpoints
// R6: zero relocks; access reads zero, resets locked
// R7: endpoint words are raw DAC counts
// R8: locked writes to calibration registers ignored
module aocal_regs (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// holding-register access from the protocol engine
	input wire aocal_pkg::aocal_req_s req,
	output logic [15:0] rdData,
	output logic rdValid,
	// input-register file lookup for the mirror window
	output logic [15:0] inAddr,
	input wire logic [15:0] inData,
	// calibration state toward the output channels
	output aocal_pkg::aocal_ends_s ends,
	output logic [15:0] spanSelect,
	output logic [15:0] zeroSelect,
	output logic spanStart,
	output logic zeroStart,
	output logic unlocked
);
	import aocal_pkg::*;

	// ****************************************************************
	// decode
	// ****************************************************************
	function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
		return a == r;
	endfunction

	logic [15:0] mirOff;
	logic inMirror;
	logic wrAccess;
	logic calWrOk;
	logic pendMirror;
	logic wrSpan;
	logic wrZero;
	logic [15:0] next_rdData;

	assign mirOff = req.addr - MIRROR_BASE;
	assign inMirror = (req.addr >= MIRROR_BASE) && (mirOff < MIRROR_SIZE);
	assign wrAccess = req.wr && hit(req.addr, ADDR_ACCESS);
	// protection gate: while locked calibration writes drop silently
	assign calWrOk = req.wr && unlocked; // R8
	// one decode per select keeps the store and the start pulse in step
	assign wrSpan = calWrOk && hit(req.addr, ADDR_SPAN_SEL); // R1
	assign wrZero = calWrOk && hit(req.addr, ADDR_ZERO_SEL); // R2

	// ****************************************************************
	// write path
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			unlocked <= 1'b0; // R6
		end else if (wrAccess && req.wdata == UNLOCK_CODE) begin
			unlocked <= 1'b1; // R3
		end else if (wrAccess && req.wdata == LOCK_CODE) begin
			unlocked <= 1'b0; // R6
		end
	end

	// raw DAC counts, stored untouched by any correction
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ends <= {4{COUNT_RESET}};
		end else if (calWrOk) begin
			if (hit(req.addr, ADDR_CH4_UPPER))
				ends.ch4Upper <= req.wdata; // R5 R7
			if (hit(req.addr, ADDR_CH4_LOWER))
				ends.ch4Lower <= req.wdata; // R5 R7
			if (hit(req.addr, ADDR_CH5_UPPER))
				ends.ch5Upper <= req.wdata; // R5 R7
			if (hit(req.addr, ADDR_CH5_LOWER))
				ends.ch5Lower <= req.wdata; // R5 R7
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			spanSelect <= SELECT_RESET;
			zeroSelect <= SELECT_RESET;
			spanStart <= 1'b0;
			zeroStart <= 1'b0;
		end else begin
			spanStart <= wrSpan; // R1
			zeroStart <= wrZero; // R2
			if (wrSpan)
				spanSelect <= req.wdata; // R1
			if (wrZero)
				zeroSelect <= req.wdata; // R2
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	// mirror reads take two cycles: address out, then input data back
	always_comb begin
		next_rdData = RSVD_READ;
		if (hit(req.addr, ADDR_ACCESS))
			next_rdData = ACCESS_READ; // R6
		else if (hit(req.addr, ADDR_CH4_UPPER))
			next_rdData = ends.ch4Upper;
		else if (hit(req.addr, ADDR_CH4_LOWER))
			next_rdData = ends.ch4Lower;
		else if (hit(req.addr, ADDR_CH5_UPPER))
			next_rdData = ends.ch5Upper;
		else if (hit(req.addr, ADDR_CH5_LOWER))
			next_rdData = ends.ch5Lower;
		else if (hit(req.addr, ADDR_SPAN_SEL))
			next_rdData = spanSelect;
		else if (hit(req.addr, ADDR_ZERO_SEL))
			next_rdData = zeroSelect;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			inAddr <= 16'h0000;
			pendMirror <= 1'b0;
			rdValid <= 1'b0;
			rdData <= 16'h0000;
		end else begin
			pendMirror <= req.rd && inMirror;
			if (req.rd && inMirror)
				inAddr <= mirOff; // R4
			rdValid <= (req.rd && !inMirror) || pendMirror;
			if (pendMirror)
				rdData <= inData; // R4
			else if (req.rd)
				rdData <= next_rdData;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_lockWrite;
		req.wr && req.addr == ADDR_ACCESS && req.wdata == LOCK_CODE;
	endsequence

	a_span_locked: assert property (@(posedge clk) disable iff (sys_rst) // R8
		!unlocked |=> $stable(spanSelect) && !spanStart)
		else $error("span select changed while locked");
	a_zero_write: assert property (@(posedge clk) disable iff (sys_rst) // R2
		unlocked && req.wr && req.addr == ADDR_ZERO_SEL && !wrAccess
		|=> zeroSelect == $past(req.wdata) && zeroStart)
		else $error("zero select not written");
	a_span_write: assert property (@(posedge clk) disable iff (sys_rst) // R1
		unlocked && req.wr && req.addr == ADDR_SPAN_SEL
		|=> spanSelect == $past(req.wdata) && spanStart)
		else $error("span select not written");
	a_unlock_code: assert property (@(posedge clk) disable iff (sys_rst) // R3
		!unlocked && !(wrAccess && req.wdata == UNLOCK_CODE) |=> !unlocked)
		else $error("unlocked without code");
	a_relock_zero: assert property (@(posedge clk) disable iff (sys_rst) // R6
		s_lockWrite |=> !unlocked)
		else $error("zero write did not relock");
	a_access_reads: assert property (@(posedge clk) disable iff (sys_rst) // R6
		req.rd && req.addr == ADDR_ACCESS |=> rdValid && rdData == 16'h0000)
		else $error("access register read nonzero");
	a_mirror_read: assert property (@(posedge clk) disable iff (sys_rst) // R4
		req.rd && inMirror |=> inAddr == $past(mirOff) ##1 rdValid
		&& rdData == $past(inData))
		else $error("mirror read wrong");
	a_ends_locked: assert property (@(posedge clk) disable iff (sys_rst) // R5
		!unlocked |=> $stable(ends))
		else $error("endpoint changed while locked");
	a_ends_store: assert property (@(posedge clk) disable iff (sys_rst) // R7
		unlocked && req.wr && req.addr == ADDR_CH5_LOWER
		|=> ends.ch5Lower == $past(req.wdata))
		else $error("endpoint count not stored");

	sequence s_mirrorReq;
		req.rd && inMirror;
	endsequence

	a_mirror_valid: assert property (@(posedge clk) disable iff (sys_rst) // R4
		s_mirrorReq |=> !rdValid ##1 rdValid)
		else $error("mirror read answered at wrong cycle");
	a_zero_locked: assert property (@(posedge clk) disable iff (sys_rst) // R8
		!unlocked |=> $stable(zeroSelect) && !zeroStart)
		else $error("zero select changed while locked");
	a_span_start: assert property (@(posedge clk) disable iff (sys_rst) // R1
		spanStart |-> $past(unlocked && req.wr && req.addr == ADDR_SPAN_SEL))
		else $error("span start without accepted write");
	a_zero_start: assert property (@(posedge clk) disable iff (sys_rst) // R2
		zeroStart |-> $past(unlocked && req.wr && req.addr == ADDR_ZERO_SEL))
		else $error("zero start without accepted write");
	a_unlock_write: assert property (@(posedge clk) disable iff (sys_rst) // R3
		wrAccess && req.wdata == UNLOCK_CODE |=> unlocked)
		else $error("unlock code did not unlock");
	a_other_code: assert property (@(posedge clk) disable iff (sys_rst) // R6
		wrAccess && req.wdata != UNLOCK_CODE && req.wdata != LOCK_CODE
		|=> unlocked == $past(unlocked))
		else $error("other access code moved the lock");
	a_ends_write: assert property (@(posedge clk) disable iff (sys_rst) // R5
		unlocked && req.wr && req.addr == ADDR_CH4_UPPER
		|=> ends.ch4Upper == $past(req.wdata))
		else $error("upper endpoint not stored");
	a_ends_read: assert property (@(posedge clk) disable iff (sys_rst) // R7
		req.rd && req.addr == ADDR_CH4_LOWER
		|=> rdValid && rdData == $past(ends.ch4Lower))
		else $error("endpoint read back wrong");
	a_span_read: assert property (@(posedge clk) disable iff (sys_rst) // R1
		req.rd && req.addr == ADDR_SPAN_SEL
		|=> rdValid && rdData == $past(spanSelect))
		else $error("span select read back wrong");
	a_zero_read: assert property (@(posedge clk) disable iff (sys_rst) // R2
		req.rd && req.addr == ADDR_ZERO_SEL
		|=> rdValid && rdData == $past(zeroSelect))
		else $error("zero select read back wrong");

	// no disable here: this one watches reset itself
	a_reset_locked: assert property (@(posedge clk) // R6
		sys_rst |=> !unlocked && !spanStart && !zeroStart)
		else $error("reset left calibration unlocked");

endmodule

// ===== dv/aocal_infile.sv
`timescale 1ns/1ps
// ****************************************
// input-register file seen by the mirror
// ****************************************
module aocal_infile (
	// lookup
	input wire logic [15:0] inAddr,
	output logic [15:0] inData
);
	// address-dependent pattern so a wrong index shows
	assign inData = inAddr ^ 16'hC3A5;
endmodule

// ===== dv/aocal_regs_bench.sv
`timescale 1ns/1ps
module aocal_regs_bench;
	import aocal_pkg::*;
	// ****************************************
	// harness
	// ****************************************
	logic clk = 0;
	logic sysRst = 1;
	aocal_req_s req = '0;
	logic [15:0] rdData, inAddr, inData, spanSelect, zeroSelect;
	aocal_ends_s ends;
	logic rdValid, spanStart, zeroStart, unlocked;
	int miscompares = 0;
	int nCompared = 0;
	always #4 clk = ~clk;
	aocal_regs dut (.clk(clk), .sys_rst(sysRst), .req(req),
		.rdData(rdData), .rdValid(rdValid), .inAddr(inAddr),
		.inData(inData), .ends(ends), .spanSelect(spanSelect),
		.zeroSelect(zeroSelect), .spanStart(spanStart),
		.zeroStart(zeroStart), .unlocked(unlocked));
	aocal_infile far (.inAddr(inAddr), .inData(inData));
	// ****************************************
	// bus tasks
	// ****************************************
	task automatic chk(input string what, input logic [15:0] exp, got);
		nCompared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [15:0] a, d);
		@(posedge clk) #1;
		req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge clk) #1;
		req.wr = 1'b0;
	endtask
	// idle edge at the end: no request right after a mirror read
	task automatic rd(input logic [15:0] a, exp, input string what);
		int i;
		@(posedge clk) #1;
		req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
		@(posedge clk) #1;
		req.rd = 1'b0;
		for (i = 0; i < 3 && rdValid !== 1'b1; i++) @(posedge clk) #1;
		chk("rdValid", 16'h0001, {15'h0000, rdValid});
		chk(what, exp, rdData);
		@(posedge clk);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_locked;
		chk("unlocked", 16'h0000, {15'h0000, unlocked});
		rd(ADDR_ACCESS, ACCESS_READ, "access");
		wr(ADDR_CH4_UPPER, 16'h0ABC);
		wr(ADDR_SPAN_SEL, 16'h0001);
		chk("spanSelect", SELECT_RESET, spanSelect);
		rd(ADDR_CH4_UPPER, COUNT_RESET, "ch4Upper");
		$display("locked test done");
	endtask
	task automatic t_ends;
		int i;
		wr(ADDR_ACCESS, UNLOCK_CODE);
		chk("unlocked", 16'h0001, {15'h0000, unlocked});
		for (i = 0; i < 4; i++)
			wr(16'(ADDR_CH4_UPPER + i), 16'(16'h0E00 + i));
		for (i = 0; i < 4; i++)
			rd(16'(ADDR_CH4_UPPER + i), 16'(16'h0E00 + i), "ends");
		chk("ch5Lower", 16'h0E03, ends.ch5Lower);
		rd(ADDR_ACCESS, ACCESS_READ, "access");
		$display("endpoint test done");
	endtask
	task automatic t_select;
		wr(ADDR_SPAN_SEL, 16'h0001);
		chk("spanStart", 16'h0001, {15'h0000, spanStart});
		chk("spanSelect", 16'h0001, spanSelect);
		wr(ADDR_ZERO_SEL, 16'h0800);
		chk("zeroStart", 16'h0001, {15'h0000, zeroStart});
		chk("zeroSelect", 16'h0800, zeroSelect);
		rd(ADDR_SPAN_SEL, 16'h0001, "spanRead");
		rd(ADDR_ZERO_SEL, 16'h0800, "zeroRead");
		rd(MIRROR_BASE + 16'h0005, 16'h0005 ^ 16'hC3A5, "mirror");
		rd(ADDR_RSVD_FIRST, RSVD_READ, "reserved");
		$display("select test done");
	endtask
	task automatic t_relock;
		wr(ADDR_ACCESS, LOCK_CODE);
		chk("unlocked", 16'h0000, {15'h0000, unlocked});
		wr(ADDR_ZERO_SEL, 16'h0001);
		chk("zeroSelect", 16'h0800, zeroSelect);
		$display("relock test done");
	endtask
	task automatic t_reset;
		wr(ADDR_ACCESS, UNLOCK_CODE);
		wr(ADDR_ACCESS, 16'h5555);
		chk("unlocked", 16'h0001, {15'h0000, unlocked});
		@(posedge clk) #1;
		sysRst = 1;
		repeat (2) @(posedge clk);
		#1 sysRst = 0;
		chk("unlocked", 16'h0000, {15'h0000, unlocked});
		chk("ch5Lower", COUNT_RESET, ends.ch5Lower);
		rd(ADDR_ACCESS, ACCESS_READ, "access");
		$display("reset test done");
	endtask
	// ****************************************
	// run control
	// ****************************************
	task automatic conclude;
		$display("compared %0d mismatched %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		#1 sysRst = 0;
		t_locked();
		t_ends();
		t_select();
		t_relock();
		t_reset();
		conclude();
	end
	// whole run is under a hundred cycles
	initial begin
		#20000;
		miscompares++;
		conclude();
	end
endmodule
